// *** logic/p5mux_pkg.sv ***
// Purpose: Shared constants and types for the pin 5 output source mux
// Assumes: One 8-bit control register reached over a plain strobe port
// Notes: Field positions and reset values live here only
package p5mux_pkg;
   localparam logic [7:0] P5MUX_CTL_OFFSET = 8'h15;
   localparam int P5MUX_SEL_LSB = 5;
   localparam int P5MUX_SRC_LSB = 2;
   localparam int P5MUX_VAL_BIT = 1;
   localparam int P5MUX_EN_BIT = 0;
   localparam logic [2:0] P5MUX_SRC_RESET = 3'h0;
   localparam logic [2:0] P5MUX_SEL_RESET = 3'h0;
   localparam logic P5MUX_VAL_RESET = 1'b0;
   localparam logic P5MUX_EN_RESET = 1'b0;
   localparam logic [2:0] P5MUX_SRC_STATUS = 3'h4;
   localparam logic [2:0] P5MUX_SRC_CSI_TX0 = 3'h6;
   localparam int P5MUX_NUM_RX = 4;

   typedef struct packed {
      logic [2:0] pin5_output_select;
      logic [2:0] pin5_output_source;
      logic pin5_output_value;
      logic pin5_output_enable;
   } p5mux_ctl_t;

   typedef struct packed {
      logic [3:0] remote_pin;
      logic lock;
      logic pass;
      logic frame_valid;
      logic line_valid;
   } p5mux_rx_t;

   typedef struct packed {
      logic pass_and;
      logic pass_or;
      logic frame_valid;
      logic line_valid;
      logic synchronized;
      logic tx_interrupt;
   } p5mux_tx_t;
endpackage

// *** logic/p5mux_regs.sv ***
// Purpose: Control register for the pin 5 output source mux
// Assumes: Read data appears in the cycle after the read strobe
// Notes: Unmapped addresses read as zero and ignore writes
`timescale 1ns/1ps
module p5mux_regs
   import p5mux_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output p5mux_ctl_t ctl
);
   p5mux_ctl_t ctl_r;
   logic [7:0] rdata_r;
   logic hit;

   assign hit = (reg_addr == P5MUX_CTL_OFFSET);
   assign ctl = ctl_r;
   assign reg_rdata = rdata_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctl_r.pin5_output_select <= P5MUX_SEL_RESET;
         ctl_r.pin5_output_source <= P5MUX_SRC_RESET;
         ctl_r.pin5_output_value <= P5MUX_VAL_RESET;
         ctl_r.pin5_output_enable <= P5MUX_EN_RESET;
      end else if (reg_write && hit) begin
         ctl_r.pin5_output_select <= reg_wdata[P5MUX_SEL_LSB +: 3];
         ctl_r.pin5_output_source <= reg_wdata[P5MUX_SRC_LSB +: 3];
         ctl_r.pin5_output_value <= reg_wdata[P5MUX_VAL_BIT];
         ctl_r.pin5_output_enable <= reg_wdata[P5MUX_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_read && hit) begin
         rdata_r <= ctl_r;
      end else begin
         rdata_r <= 8'h00;
      end
   end
endmodule

// *** logic/p5mux_sync.sv ***
// Purpose: Two-stage synchroniser for a bus of levels
// Assumes: Inputs are slow levels from outside the core clock
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module p5mux_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
   assign q = q_r;
endmodule

// *** logic/p5mux_top.sv ***
// Purpose: Output source multiplexer for general purpose pin 5
// Assumes: Routed status signals come from core logic on ref_clk, except remote pins
// Notes: Remote pin levels arrive from link receivers and are synchronised here
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

module p5mux_top
   import p5mux_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic [15:0] remote_pin_async,
   input wire p5mux_rx_t [3:0] rx_status,
   input wire logic [3:0] rx_port_enabled,
   input wire logic frame_sync_pulse,
   input wire p5mux_tx_t tx_status,
   output logic general_pin_5_out,
   output logic general_pin_5_oe
);
   p5mux_ctl_t ctl;
   logic [15:0] remote_pin;
   logic mux_nxt;
   logic pin_r;
   logic oe_r;

   p5mux_regs u_regs (
      .ref_clk(ref_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .ctl(ctl)
   );

   // Remote pins cross from the link receivers, so they are resynchronised
   p5mux_sync #(.W(16)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(remote_pin_async),
      .q(remote_pin)
   );

   function automatic logic rx_pick(input p5mux_rx_t rx, input logic [3:0] rpin,
                                    input logic [2:0] sel);
      logic r;
      r = 1'b0;
      unique case (sel)
         3'h0, 3'h1, 3'h2, 3'h3: r = rpin[sel[1:0]];
         3'h4: r = rx.lock;
         3'h5: r = rx.pass;
         3'h6: r = rx.frame_valid;
         3'h7: r = rx.line_valid;
      endcase
      return r;
   endfunction

   always_comb begin
      logic lock_any;
      logic pass_all;
      lock_any = 1'b0;
      pass_all = 1'b1;
      for (int i = 0; i < P5MUX_NUM_RX; i++) begin
         lock_any = lock_any | (rx_port_enabled[i] & rx_status[i].lock);
         pass_all = pass_all & (~rx_port_enabled[i] | rx_status[i].pass);
      end
      mux_nxt = 1'b0;
      if (!ctl.pin5_output_source[2]) begin
         mux_nxt = rx_pick(rx_status[ctl.pin5_output_source[1:0]],
                           remote_pin[4*ctl.pin5_output_source[1:0] +: 4],
                           ctl.pin5_output_select);
      end else if (ctl.pin5_output_source == P5MUX_SRC_STATUS) begin
         unique case (ctl.pin5_output_select)
            3'h0: mux_nxt = ctl.pin5_output_value;
            3'h1: mux_nxt = lock_any;
            3'h2, 3'h3: mux_nxt = pass_all;
            3'h4: mux_nxt = frame_sync_pulse;
            default: mux_nxt = 1'b0;
         endcase
      end else if (ctl.pin5_output_source == P5MUX_SRC_CSI_TX0) begin
         unique case (ctl.pin5_output_select)
            3'h0: mux_nxt = tx_status.pass_and;
            3'h1: mux_nxt = tx_status.pass_or;
            3'h2: mux_nxt = tx_status.frame_valid;
            3'h3: mux_nxt = tx_status.line_valid;
            3'h4: mux_nxt = tx_status.synchronized;
            3'h5: mux_nxt = tx_status.tx_interrupt;
            default: mux_nxt = 1'b0;
         endcase
      end
   end

   // Registering costs a cycle of latency but keeps select changes glitch free
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_r <= 1'b0;
      end else begin
         pin_r <= mux_nxt;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= ctl.pin5_output_enable;
      end
   end

   assign general_pin_5_out = pin_r;
   assign general_pin_5_oe = oe_r;

   mux_regd_a: assert property (@(posedge ref_clk) disable iff (rst)
      ##1 general_pin_5_out == $past(mux_nxt))
      else $error("pin output is not the mux value of the previous cycle");
   oe_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
      ##1 general_pin_5_oe == $past(ctl.pin5_output_enable))
      else $error("output enable does not follow control bit");
   status_val_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == P5MUX_SRC_STATUS && ctl.pin5_output_select == 3'h0)
      |=> general_pin_5_out == $past(ctl.pin5_output_value))
      else $error("status source 000 does not drive output value");
   lock_or_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == P5MUX_SRC_STATUS && ctl.pin5_output_select == 3'h1)
      |=> general_pin_5_out == $past(|(rx_port_enabled &
         {rx_status[3].lock, rx_status[2].lock, rx_status[1].lock, rx_status[0].lock})))
      else $error("lock OR wrong");
   pass_and_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == P5MUX_SRC_STATUS && ctl.pin5_output_select[2:1] == 2'h1)
      |=> general_pin_5_out == $past(&(~rx_port_enabled |
         {rx_status[3].pass, rx_status[2].pass, rx_status[1].pass, rx_status[0].pass})))
      else $error("pass AND wrong");
   sync_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == P5MUX_SRC_STATUS && ctl.pin5_output_select == 3'h4)
      |=> general_pin_5_out == $past(frame_sync_pulse))
      else $error("frame sync not routed");
   tx_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == P5MUX_SRC_CSI_TX0 && ctl.pin5_output_select == 3'h2)
      |=> general_pin_5_out == $past(tx_status.frame_valid))
      else $error("tx frame valid not routed");
   tx_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == P5MUX_SRC_CSI_TX0 && ctl.pin5_output_select == 3'h5)
      |=> general_pin_5_out == $past(tx_status.tx_interrupt))
      else $error("tx interrupt not routed");
   reserved_low_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == 3'h5 || ctl.pin5_output_source == 3'h7 ||
       (ctl.pin5_output_source == P5MUX_SRC_CSI_TX0 && ctl.pin5_output_select[2:1] == 2'h3))
      |=> !general_pin_5_out)
      else $error("reserved code drives high");
   rx_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctl.pin5_output_source == 3'h1 && ctl.pin5_output_select == 3'h4)
      |=> general_pin_5_out == $past(rx_status[1].lock))
      else $error("rx port 1 lock not routed");

   cov_rx_remote: cover property (@(posedge ref_clk) disable iff (rst)
      !ctl.pin5_output_source[2] && ctl.pin5_output_select == 3'h2 && general_pin_5_out);
   cov_status: cover property (@(posedge ref_clk) disable iff (rst)
      ctl.pin5_output_source == P5MUX_SRC_STATUS && general_pin_5_oe && general_pin_5_out);
   cov_tx: cover property (@(posedge ref_clk) disable iff (rst)
      ctl.pin5_output_source == P5MUX_SRC_CSI_TX0 && general_pin_5_out);
endmodule

// *** verification/p5mux_pin_load.sv ***
// Purpose: Load on general pin 5 as seen from the board
// Assumes: A weak pull sets the level while no one drives the pin
// Notes: Released pin falls to the pull level, never keeps the last value
`timescale 1ns/1ps
module p5mux_pin_load #(
   parameter logic PULL = 1'b0
) (
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_level
);
   assign pin_level = pin_oe ? pin_out : PULL;
endmodule

// *** verification/p5mux_top_tb.sv ***
// Purpose: Self-checking bench for the pin 5 output source mux
// Assumes: All status inputs held steady long enough for the synchroniser
// Notes: Every source and select code is walked with each value and enable, then random configs
`timescale 1ns/1ps
module p5mux_top_tb;
   import p5mux_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic [15:0] remote_pin_async = 16'h0000;
   p5mux_rx_t [3:0] rx_status = '0;
   logic [3:0] rx_port_enabled = 4'h0;
   logic frame_sync_pulse = 1'b0;
   p5mux_tx_t tx_status = '0;
   logic pin_out;
   logic pin_oe;
   logic pin_level;
   logic [7:0] rd;
   logic [7:0] c;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   int seed = 32'he4f9f31b;

   always #50 ref_clk = ~ref_clk;

   p5mux_top p5mux_top_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .remote_pin_async(remote_pin_async), .rx_status(rx_status),
      .rx_port_enabled(rx_port_enabled), .frame_sync_pulse(frame_sync_pulse),
      .tx_status(tx_status), .general_pin_5_out(pin_out), .general_pin_5_oe(pin_oe));
   p5mux_pin_load p5mux_pin_load_inst (.pin_out(pin_out), .pin_oe(pin_oe),
      .pin_level(pin_level));

   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Ceiling is several times the expected run of about 3600 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error %0t register read %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_pin(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error %0t pin %b expected %b cfg %h", $time, g, e, c);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      // Read data must stand for one cycle only and then return to zero
      @(posedge ref_clk);
      #1 chk_reg(reg_rdata, 8'h00);
   endtask

   task automatic rand_inputs();
      @(posedge ref_clk);
      remote_pin_async <= 16'($random(seed));
      rx_status <= $random(seed);
      rx_port_enabled <= 4'($random(seed));
      frame_sync_pulse <= 1'($random(seed));
      tx_status <= 6'($random(seed));
   endtask

   // Disabled ports count as lock 0 and pass 1
   function automatic logic exp_pin(input logic [7:0] cv);
      logic [2:0] sel;
      logic [2:0] src;
      logic lk;
      logic ps;
      logic r;
      sel = cv[7:5];
      src = cv[4:2];
      lk = 1'b0;
      ps = 1'b1;
      r = 1'b0;
      for (int p = 0; p < 4; p++) begin
         if (rx_port_enabled[p]) lk |= rx_status[p].lock;
         if (rx_port_enabled[p]) ps &= rx_status[p].pass;
      end
      if (!src[2]) begin
         case (sel)
            3'h4: r = rx_status[src[1:0]].lock;
            3'h5: r = rx_status[src[1:0]].pass;
            3'h6: r = rx_status[src[1:0]].frame_valid;
            3'h7: r = rx_status[src[1:0]].line_valid;
            default: r = remote_pin_async[{src[1:0], sel[1:0]}];
         endcase
      end else if (src == P5MUX_SRC_STATUS) begin
         case (sel)
            3'h0: r = cv[1];
            3'h1: r = lk;
            3'h2, 3'h3: r = ps;
            3'h4: r = frame_sync_pulse;
            default: r = 1'b0;
         endcase
      end else if (src == P5MUX_SRC_CSI_TX0) begin
         case (sel)
            3'h0: r = tx_status.pass_and;
            3'h1: r = tx_status.pass_or;
            3'h2: r = tx_status.frame_valid;
            3'h3: r = tx_status.line_valid;
            3'h4: r = tx_status.synchronized;
            3'h5: r = tx_status.tx_interrupt;
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction

   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      rd_reg(P5MUX_CTL_OFFSET, rd);
      chk_reg(rd, 8'h00);
      chk_pin(pin_oe, 1'b0);
      chk_pin(pin_level, 1'b0);
      // First 256 passes walk every source, select, value and enable
      for (int i = 0; i < 356; i++) begin
         c = (i < 256) ? 8'(i) : 8'($random(seed));
         rand_inputs();
         wr_reg(P5MUX_CTL_OFFSET, c);
         rd_reg(P5MUX_CTL_OFFSET, rd);
         chk_reg(rd, c);
         repeat (4) @(posedge ref_clk);
         #1 chk_pin(pin_out, exp_pin(c));
         chk_pin(pin_oe, c[0]);
         chk_pin(pin_level, c[0] & exp_pin(c));
      end
      wr_reg(8'h14, 8'hff);
      rd_reg(P5MUX_CTL_OFFSET, rd);
      chk_reg(rd, c);
      rd_reg(8'h14, rd);
      chk_reg(rd, 8'h00);
      // Frame sync path must follow after exactly one register stage
      c = 8'h91;
      wr_reg(P5MUX_CTL_OFFSET, c);
      repeat (4) @(posedge ref_clk);
      frame_sync_pulse <= ~frame_sync_pulse;
      #1 chk_pin(pin_out, ~frame_sync_pulse);
      @(posedge ref_clk);
      #1 chk_pin(pin_out, frame_sync_pulse);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      #1 chk_pin(pin_oe, 1'b0);
      rd_reg(P5MUX_CTL_OFFSET, rd);
      chk_reg(rd, 8'h00);
      wrap_up();
   end
endmodule
